// ===== hdl/nibble_logic_bit_skip_unit.sv
`timescale 1ns/1ps
// Operation
// - AND writes work register AND memory_at_pointer back into the work register.
// - OR writes work register OR memory_at_pointer back into the work register.
// - Set-carry forces carry_flag to 1 and changes nothing else.
// - Clear-carry forces carry_flag to 0 and changes nothing else.
// - Skip-on-carry-clear skips the next instruction when carry_flag is 0.
// - Complement inverts every work register bit and leaves carry_flag alone.
// - Rotate shifts the work register right through carry_flag.
// - Bit-set writes 1 to the selected bit of memory_at_pointer, others kept.
// - Bit-clear writes 0 to the selected bit of memory_at_pointer, others kept.
// - Bit-test skips the next instruction when the selected bit is 0.
// - Memory compare skips the next instruction when work register equals memory.
// - Immediate compare skips the next instruction when work register equals immediate.
module nibble_logic_bit_skip_unit (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire nibble_logic_pkg::instr_type i_instr,
  input wire logic [nibble_logic_pkg::NIBBLE_W-1:0] i_memory_at_pointer,
  output logic [nibble_logic_pkg::NIBBLE_W-1:0] o_work,
  output logic o_carry_flag,
  output nibble_logic_pkg::mem_wr_type o_mem_wr,
  output logic o_skip_active
);
  logic [nibble_logic_pkg::NIBBLE_W-1:0] work_reg;
  logic [nibble_logic_pkg::NIBBLE_W-1:0] work_next;
  logic carry_reg;
  logic carry_next;
  nibble_logic_pkg::mem_wr_type mem_wr_reg;
  nibble_logic_pkg::mem_wr_type mem_wr_next;
  logic skip_request;
  logic live;
  logic [nibble_logic_pkg::BIT_IDX_W-1:0] bit_idx;
  logic [nibble_logic_pkg::NIBBLE_W-1:0] bit_mask;

  assign bit_idx = i_instr.imm[nibble_logic_pkg::BIT_IDX_W-1:0];
  assign bit_mask = nibble_logic_pkg::NIBBLE_W'(1) << bit_idx;
  // The instruction after a met skip condition is only a slot filler
  assign live = i_instr.valid & ~o_skip_active;

  // ****************************************
  // Next-state decode
  // ****************************************
  always_comb begin
    work_next = work_reg;
    carry_next = carry_reg;
    mem_wr_next = '0;
    skip_request = 1'b0;
    if (live) begin
      case (i_instr.op)
        nibble_logic_pkg::OP_AND: begin
          work_next = work_reg & i_memory_at_pointer;
        end
        nibble_logic_pkg::OP_OR: begin
          work_next = work_reg | i_memory_at_pointer;
        end
        nibble_logic_pkg::OP_SET_CARRY: begin
          carry_next = nibble_logic_pkg::CARRY_ONE;
        end
        nibble_logic_pkg::OP_CLR_CARRY: begin
          carry_next = nibble_logic_pkg::CARRY_ZERO;
        end
        nibble_logic_pkg::OP_SKIP_NC: begin
          skip_request = ~carry_reg;
        end
        nibble_logic_pkg::OP_COMPLEMENT: begin
          work_next = ~work_reg;
        end
        nibble_logic_pkg::OP_ROTATE: begin
          work_next = {carry_reg, work_reg[nibble_logic_pkg::MSB:1]};
          carry_next = work_reg[0];
        end
        nibble_logic_pkg::OP_BIT_SET: begin
          mem_wr_next.write = 1'b1;
          mem_wr_next.data = i_memory_at_pointer | bit_mask;
        end
        nibble_logic_pkg::OP_BIT_CLR: begin
          mem_wr_next.write = 1'b1;
          mem_wr_next.data = i_memory_at_pointer & ~bit_mask;
        end
        nibble_logic_pkg::OP_BIT_TEST: begin
          skip_request = ~i_memory_at_pointer[bit_idx];
        end
        nibble_logic_pkg::OP_CMP_MEM: begin
          skip_request = (work_reg == i_memory_at_pointer);
        end
        nibble_logic_pkg::OP_CMP_IMM: begin
          skip_request = (work_reg == i_instr.imm);
        end
        default: begin
          work_next = work_reg;
        end
      endcase
    end
  end

  // ****************************************
  // Work register and carry
  // ****************************************
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      work_reg <= nibble_logic_pkg::WORK_RESET;
    end else begin
      work_reg <= work_next;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      carry_reg <= nibble_logic_pkg::CARRY_RESET;
    end else begin
      carry_reg <= carry_next;
    end
  end

  // Memory write is a one-cycle registered strobe; the RAM owner applies it
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      mem_wr_reg <= '0;
    end else begin
      mem_wr_reg <= mem_wr_next;
    end
  end

  assign o_work = work_reg;
  assign o_carry_flag = carry_reg;
  assign o_mem_wr = mem_wr_reg;

  skip_tracker u_skip (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_valid(i_instr.valid),
    .i_skip_request(skip_request),
    .o_skip_active(o_skip_active)
  );

  // ****************************************
  // Checks
  // ****************************************
  property p_and_result;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_AND) |=>
      o_work == ($past(o_work) & $past(i_memory_at_pointer));
  endproperty
  a_and_result: assert property (p_and_result) else $error("AND result wrong");

  property p_or_result;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_OR) |=>
      o_work == ($past(o_work) | $past(i_memory_at_pointer));
  endproperty
  a_or_result: assert property (p_or_result) else $error("OR result wrong");

  property p_set_carry;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_SET_CARRY) |=>
      o_carry_flag && $stable(o_work);
  endproperty
  a_set_carry: assert property (p_set_carry) else $error("Carry not set");

  property p_clr_carry;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_CLR_CARRY) |=>
      !o_carry_flag && $stable(o_work);
  endproperty
  a_clr_carry: assert property (p_clr_carry) else $error("Carry not cleared");

  property p_skip_nc;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_SKIP_NC) |=> o_skip_active == !$past(o_carry_flag);
  endproperty
  a_skip_nc: assert property (p_skip_nc) else $error("Carry skip wrong");

  property p_complement;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_COMPLEMENT) |=>
      o_work == ~$past(o_work) && $stable(o_carry_flag);
  endproperty
  a_complement: assert property (p_complement) else $error("Complement wrong");

  property p_rotate;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_ROTATE) |=>
      {o_work, o_carry_flag} == {$past(o_carry_flag), $past(o_work)};
  endproperty
  a_rotate: assert property (p_rotate) else $error("Rotate wrong");

  property p_bit_set;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_BIT_SET) |=>
      o_mem_wr.write &&
      o_mem_wr.data == ($past(i_memory_at_pointer) | (4'h1 << $past(i_instr.imm[1:0])));
  endproperty
  a_bit_set: assert property (p_bit_set) else $error("Bit set wrong");

  property p_bit_clr;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_BIT_CLR) |=>
      o_mem_wr.write &&
      o_mem_wr.data == ($past(i_memory_at_pointer) & ~(4'h1 << $past(i_instr.imm[1:0])));
  endproperty
  a_bit_clr: assert property (p_bit_clr) else $error("Bit clear wrong");

  property p_bit_test;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_BIT_TEST) |=>
      o_skip_active == !$past(i_memory_at_pointer[bit_idx]);
  endproperty
  a_bit_test: assert property (p_bit_test) else $error("Bit test skip wrong");

  property p_cmp_mem;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_CMP_MEM) |=>
      o_skip_active == ($past(o_work) == $past(i_memory_at_pointer));
  endproperty
  a_cmp_mem: assert property (p_cmp_mem) else $error("Memory compare wrong");

  property p_cmp_imm;
    @(posedge i_clock) disable iff (i_sys_rst)
    (live && i_instr.op == nibble_logic_pkg::OP_CMP_IMM) |=>
      o_skip_active == ($past(o_work) == $past(i_instr.imm));
  endproperty
  a_cmp_imm: assert property (p_cmp_imm) else $error("Immediate compare wrong");

  property p_skip_inert;
    @(posedge i_clock) disable iff (i_sys_rst)
    (o_skip_active && i_instr.valid) |=>
      $stable(o_work) && $stable(o_carry_flag) && !o_mem_wr.write && !o_skip_active;
  endproperty
  a_skip_inert: assert property (p_skip_inert) else $error("Skipped slot changed state");
endmodule

// ===== include/nibble_logic_pkg.sv
package nibble_logic_pkg;
  localparam int unsigned NIBBLE_W = 4;
  localparam int unsigned BIT_IDX_W = 2;
  localparam logic [3:0] WORK_RESET = 4'h0;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic CARRY_ONE = 1'b1;
  localparam logic CARRY_ZERO = 1'b0;
  localparam int unsigned MSB = NIBBLE_W - 1;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_AND = 4'h1,
    OP_OR = 4'h2,
    OP_SET_CARRY = 4'h3,
    OP_CLR_CARRY = 4'h4,
    OP_SKIP_NC = 4'h5,
    OP_COMPLEMENT = 4'h6,
    OP_ROTATE = 4'h7,
    OP_BIT_SET = 4'h8,
    OP_BIT_CLR = 4'h9,
    OP_BIT_TEST = 4'ha,
    OP_CMP_MEM = 4'hb,
    OP_CMP_IMM = 4'hc
  } op_type;

  // One decoded instruction per valid cycle
  typedef struct packed {
    logic valid;
    op_type op;
    logic [NIBBLE_W-1:0] imm;
  } instr_type;

  // Write-back of the nibble at the data pointer
  typedef struct packed {
    logic write;
    logic [NIBBLE_W-1:0] data;
  } mem_wr_type;
endpackage

// ===== hdl/skip_tracker.sv
`timescale 1ns/1ps
// Holds the pending-skip state: a met condition kills exactly the next valid instruction.
module skip_tracker (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_valid,
  input wire logic i_skip_request,
  output logic o_skip_active
);
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      o_skip_active <= 1'b0;
    end else if (i_valid) begin
      // A skipped instruction cannot itself request a skip
      o_skip_active <= i_skip_request & ~o_skip_active;
    end
  end
endmodule

// ===== tb/nibble_logic_bit_skip_unit_tb_top.sv
`timescale 1ns/1ps
module nibble_logic_bit_skip_unit_tb_top;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  nibble_logic_pkg::instr_type i_instr = '0;
  logic [3:0] i_memory_at_pointer = 4'h0;
  logic [3:0] o_work;
  logic o_carry_flag;
  nibble_logic_pkg::mem_wr_type o_mem_wr;
  logic o_skip_active;
  integer seed = 32'hcf44;
  int bad_count = 0;
  int compares = 0;
  logic [3:0] m_work;
  logic [3:0] m_wr_data;
  logic m_carry;
  logic m_skip;
  logic m_wr;
  bit primed = 1'b0;

  nibble_logic_bit_skip_unit u_dut (
    .i_clock(i_clock),
    .i_sys_rst(i_sys_rst),
    .i_instr(i_instr),
    .i_memory_at_pointer(i_memory_at_pointer),
    .o_work(o_work),
    .o_carry_flag(o_carry_flag),
    .o_mem_wr(o_mem_wr),
    .o_skip_active(o_skip_active)
  );

  initial begin
    forever #2 i_clock = ~i_clock;
  end

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic check_nib(input logic [3:0] got, input logic [3:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ****************************************
  // Reference model, state after the next edge
  // ****************************************
  task automatic model_step(input logic rst, input nibble_logic_pkg::instr_type ins,
                            input logic [3:0] mem);
    logic [3:0] w;
    logic c;
    logic [3:0] sel;
    w = m_work;
    c = m_carry;
    sel = 4'h1 << ins.imm[1:0];
    m_wr = 1'b0;
    if (rst) begin
      m_work = 4'h0;
      m_carry = 1'b0;
      m_skip = 1'b0;
    end else if (ins.valid && m_skip) begin
      m_skip = 1'b0;
    end else if (ins.valid) begin
      case (ins.op)
        nibble_logic_pkg::OP_AND: m_work = w & mem;
        nibble_logic_pkg::OP_OR: m_work = w | mem;
        nibble_logic_pkg::OP_SET_CARRY: m_carry = 1'b1;
        nibble_logic_pkg::OP_CLR_CARRY: m_carry = 1'b0;
        nibble_logic_pkg::OP_SKIP_NC: m_skip = (c == 1'b0);
        nibble_logic_pkg::OP_COMPLEMENT: m_work = ~w;
        nibble_logic_pkg::OP_ROTATE: begin
          m_work = {c, w[3:1]};
          m_carry = w[0];
        end
        nibble_logic_pkg::OP_BIT_SET: begin
          m_wr = 1'b1;
          m_wr_data = mem | sel;
        end
        nibble_logic_pkg::OP_BIT_CLR: begin
          m_wr = 1'b1;
          m_wr_data = mem & ~sel;
        end
        nibble_logic_pkg::OP_BIT_TEST: m_skip = (mem[ins.imm[1:0]] == 1'b0);
        nibble_logic_pkg::OP_CMP_MEM: m_skip = (w == mem);
        nibble_logic_pkg::OP_CMP_IMM: m_skip = (w == ins.imm);
        default: ;
      endcase
    end
  endtask

  // ****************************************
  // Random stimulus with a reset in mid-run
  // ****************************************
  initial begin
    int i;
    logic rst;
    logic [3:0] mem;
    nibble_logic_pkg::instr_type ins;
    for (i = 0; i < 2500; i++) begin
      @(negedge i_clock);
      if (primed) begin
        check_nib(o_work, m_work);
        check_flag(o_carry_flag, m_carry);
        check_flag(o_skip_active, m_skip);
        check_flag(o_mem_wr.write, m_wr);
        if (m_wr) check_nib(o_mem_wr.data, m_wr_data);
      end
      rst = (i < 11) || (i >= 1200 && i < 1202);
      ins.valid = (($random(seed) & 3) != 0);
      // Codes above the last opcode are drawn too; they must change nothing
      ins.op = nibble_logic_pkg::op_type'(4'($unsigned($random(seed)) % 16));
      ins.imm = 4'($random(seed));
      mem = 4'($random(seed));
      // Equal operands often enough to reach every skip outcome
      if ($random(seed) & 1) ins.imm = m_work;
      if ($random(seed) & 1) mem = m_work;
      model_step(rst, ins, mem);
      primed = 1'b1;
      i_sys_rst = rst;
      i_instr = ins;
      i_memory_at_pointer = mem;
    end
    end_of_test();
  end

  // Run needs about 10 us; a hang is cut off well beyond that
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
endmodule
